// >>> hdl/dual_prescaled_counter.sv
// Two prescaled counter blocks with capture registers and a plain register port
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "prescaled_counter_params.svh"

module dual_prescaled_counter
(
   // Clock and reset
   input  wire logic                           clk_sys_i,
   input  wire logic                           rst_i,
   // Register port
   input  wire prescaled_counter_pkg::reg_req_t req_i,
   output logic [31:0]                         rdata_o,
   // External events and debug
   input  wire logic [1:0]                     capture_source_i,
   input  wire logic                           suspend_i
);
   import prescaled_counter_pkg::*;

   counter_state_t st;
   counter_state_t next_st;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] incr(input logic [31:0] v);
      incr = v + `COUNT_STEP; // RL18
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic       run [2];
   logic       cap [2];
   logic       match [2];
   logic [7:0] ofs_free [2];
   logic [7:0] ofs_pre [2];
   logic [7:0] ofs_lim [2];
   logic [7:0] ofs_cfree [2];
   logic [7:0] ofs_cpre [2];

   assign ofs_free  = '{`OFS_FREE_RUNNING_0, `OFS_FREE_RUNNING_1};
   assign ofs_pre   = '{`OFS_PRESCALE_COUNT_0, `OFS_PRESCALE_COUNT_1};
   assign ofs_lim   = '{`OFS_PRESCALE_COMPARE_0, `OFS_PRESCALE_COMPARE_1};
   assign ofs_cfree = '{`OFS_CAPT_FREE_0, `OFS_CAPT_FREE_1};
   assign ofs_cpre  = '{`OFS_CAPT_PRESCALE_0, `OFS_CAPT_PRESCALE_1};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      logic       halted;
      logic [1:0] rise;
      logic       sel;
      halted = 1'b0;
      rise   = 2'b00;
      sel    = 1'b0;
      next_st = st;
      // Beyond the shift, only the sync stages and the capture prev stage are read below
      next_st.cap_src_meta = capture_source_i;
      next_st.cap_src_sync = st.cap_src_meta;
      next_st.cap_src_prev = st.cap_src_sync;
      next_st.suspend_meta = suspend_i;
      next_st.suspend_sync = st.suspend_meta;
      rise = st.cap_src_sync & ~st.cap_src_prev;
      halted = st.suspend_sync && !st.continue_on_suspend; // RL17

      for (int b = 0; b < 2; b++)
      begin
         run[b] = ((b == 0) ? st.block_zero_enable : st.block_one_enable) && !halted; // RL15
         sel = (b == 0) ? st.block_zero_capture_select : st.block_one_capture_select;
         cap[b] = sel ? rise[1] : rise[0]; // RL16
         // Exact equality only: a preset above the limit wraps before matching
         match[b] = (st.blk[b].prescale == st.blk[b].limit); // RL3 RL11 RL6 RL13
         if (run[b])
         begin
            if (match[b])
            begin
               next_st.blk[b].prescale = `RESET_WORD; // RL3 RL11 RL4
               next_st.blk[b].free_run = incr(st.blk[b].free_run); // RL3 RL11 RL18
            end
            else
               next_st.blk[b].prescale = incr(st.blk[b].prescale); // RL6 RL13 RL18
         end
         if (cap[b])
         begin
            next_st.blk[b].snap_free     = st.blk[b].free_run; // RL7 RL14
            next_st.blk[b].snap_prescale = st.blk[b].prescale; // RL8 RL14
         end
         // Software writes win over counting in the same cycle
         if (req_i.wr)
         begin
            if (hit(req_i.addr, ofs_free[b]))
               next_st.blk[b].free_run = req_i.wdata; // RL1 RL10
            if (hit(req_i.addr, ofs_pre[b]))
            begin
               next_st.blk[b].prescale      = req_i.wdata; // RL13
               next_st.blk[b].prescale_view = req_i.wdata;
            end
            if (hit(req_i.addr, ofs_lim[b]))
               next_st.blk[b].limit = req_i.wdata;
         end
         if (req_i.rd && hit(req_i.addr, ofs_free[b]))
            next_st.blk[b].prescale_view = st.blk[b].prescale; // RL5 RL12
         if (req_i.rd && hit(req_i.addr, ofs_cfree[b]))
            next_st.blk[b].snap_prescale_view = st.blk[b].snap_prescale; // RL9 RL14
      end

      if (req_i.wr && hit(req_i.addr, `OFS_GLOBAL_CONTROL))
      begin
         next_st.block_zero_enable   = req_i.wdata[`BIT_BLOCK_ZERO_ENABLE];
         next_st.block_one_enable    = req_i.wdata[`BIT_BLOCK_ONE_ENABLE];
         next_st.continue_on_suspend = req_i.wdata[`BIT_CONTINUE_SUSPEND];
      end
      if (req_i.wr && hit(req_i.addr, `OFS_CAPTURE_SOURCE))
      begin
         next_st.block_zero_capture_select = req_i.wdata[`BIT_BLOCK_ZERO_CAPSEL];
         next_st.block_one_capture_select  = req_i.wdata[`BIT_BLOCK_ONE_CAPSEL];
      end

      // Read data stands only in the cycle after the strobe
      next_st.rdata = `UNMAPPED_READ;
      if (req_i.rd)
      begin
         if (hit(req_i.addr, `OFS_GLOBAL_CONTROL))
         begin
            next_st.rdata[`BIT_BLOCK_ZERO_ENABLE] = st.block_zero_enable;
            next_st.rdata[`BIT_BLOCK_ONE_ENABLE]  = st.block_one_enable;
            next_st.rdata[`BIT_CONTINUE_SUSPEND]  = st.continue_on_suspend;
         end
         if (hit(req_i.addr, `OFS_CAPTURE_SOURCE))
         begin
            next_st.rdata[`BIT_BLOCK_ZERO_CAPSEL] = st.block_zero_capture_select;
            next_st.rdata[`BIT_BLOCK_ONE_CAPSEL]  = st.block_one_capture_select;
         end
         for (int b = 0; b < 2; b++)
         begin
            if (hit(req_i.addr, ofs_free[b]))
               next_st.rdata = st.blk[b].free_run; // RL1 RL10
            if (hit(req_i.addr, ofs_pre[b]))
               next_st.rdata = st.blk[b].prescale_view; // RL5 RL12
            if (hit(req_i.addr, ofs_lim[b]))
               next_st.rdata = st.blk[b].limit;
            if (hit(req_i.addr, ofs_cfree[b]))
               next_st.rdata = st.blk[b].snap_free;
            if (hit(req_i.addr, ofs_cpre[b]))
               next_st.rdata = st.blk[b].snap_prescale_view; // RL9 RL14
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign rdata_o = st.rdata;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic halted_a;
   assign halted_a = st.suspend_sync && !st.continue_on_suspend;

   property p_match0_clears;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_zero_enable && !halted_a && st.blk[0].prescale == st.blk[0].limit && !req_i.wr)
      |=> (st.blk[0].prescale == `RESET_WORD && st.blk[0].free_run == $past(st.blk[0].free_run) + `COUNT_STEP);
   endproperty
   a_match0_clears: assert property (p_match0_clears) else $error("block 0 match did not clear/advance"); // RL3

   property p_match1_clears;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_one_enable && !halted_a && st.blk[1].prescale == st.blk[1].limit && !req_i.wr)
      |=> (st.blk[1].prescale == `RESET_WORD && st.blk[1].free_run == $past(st.blk[1].free_run) + `COUNT_STEP);
   endproperty
   a_match1_clears: assert property (p_match1_clears) else $error("block 1 match did not clear/advance"); // RL11

   property p_nomatch0_counts;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_zero_enable && !halted_a && st.blk[0].prescale != st.blk[0].limit && !req_i.wr)
      |=> (st.blk[0].prescale == $past(st.blk[0].prescale) + 32'h1) && $stable(st.blk[0].free_run);
   endproperty
   a_nomatch0_counts: assert property (p_nomatch0_counts) else $error("block 0 prescale did not count"); // RL6

   property p_disabled_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
      (!st.block_zero_enable && !req_i.wr) |=> $stable(st.blk[0].prescale) && $stable(st.blk[0].free_run);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("disabled block 0 counted"); // RL15

   property p_suspend_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
      (halted_a && !req_i.wr) |=> $stable(st.blk[1].prescale) && $stable(st.blk[1].free_run);
   endproperty
   a_suspend_hold: assert property (p_suspend_hold) else $error("counter ran in suspend"); // RL17

   property p_view_refresh;
      @(posedge clk_sys_i) disable iff (rst_i)
      (req_i.rd && req_i.addr == `OFS_FREE_RUNNING_0 && !req_i.wr) |=> st.blk[0].prescale_view == $past(st.blk[0].prescale);
   endproperty
   a_view_refresh: assert property (p_view_refresh) else $error("prescale view not refreshed"); // RL5

   property p_view_steady;
      @(posedge clk_sys_i) disable iff (rst_i)
      !((req_i.rd || req_i.wr) && (req_i.addr == `OFS_FREE_RUNNING_1 || req_i.addr == `OFS_PRESCALE_COUNT_1))
      |=> $stable(st.blk[1].prescale_view);
   endproperty
   a_view_steady: assert property (p_view_steady) else $error("prescale view 1 changed unasked"); // RL12

   property p_capture0;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_zero_capture_select ? (st.cap_src_sync[1] && !st.cap_src_prev[1])
                                     : (st.cap_src_sync[0] && !st.cap_src_prev[0]))
      |=> st.blk[0].snap_free == $past(st.blk[0].free_run) && st.blk[0].snap_prescale == $past(st.blk[0].prescale);
   endproperty
   a_capture0: assert property (p_capture0) else $error("block 0 capture missed"); // RL7

   sequence s_snap_read1;
      req_i.rd && req_i.addr == `OFS_CAPT_FREE_1;
   endsequence

   property p_snap_pair1;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_snap_read1 |=> st.blk[1].snap_prescale_view == $past(st.blk[1].snap_prescale);
   endproperty
   a_snap_pair1: assert property (p_snap_pair1) else $error("block 1 snapshot pair broken"); // RL14

   // ----------------------------------------
   // Block 1 counting, block 0 suspend
   // ----------------------------------------
   property p_nomatch1_counts;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_one_enable && !halted_a && st.blk[1].prescale != st.blk[1].limit && !req_i.wr)
      |=> (st.blk[1].prescale == $past(st.blk[1].prescale) + `COUNT_STEP) && $stable(st.blk[1].free_run);
   endproperty
   a_nomatch1_counts: assert property (p_nomatch1_counts) else $error("block 1 prescale did not count"); // RL13

   property p_disabled_hold1;
      @(posedge clk_sys_i) disable iff (rst_i)
      (!st.block_one_enable && !req_i.wr) |=> $stable(st.blk[1].prescale) && $stable(st.blk[1].free_run);
   endproperty
   a_disabled_hold1: assert property (p_disabled_hold1) else $error("disabled block 1 counted"); // RL15

   property p_suspend_hold0;
      @(posedge clk_sys_i) disable iff (rst_i)
      (halted_a && !req_i.wr) |=> $stable(st.blk[0].prescale) && $stable(st.blk[0].free_run);
   endproperty
   a_suspend_hold0: assert property (p_suspend_hold0) else $error("block 0 ran in suspend"); // RL17

   // Wrap through all ones, the path a preset above the limit takes
   property p_wrap0;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_zero_enable && !halted_a && st.blk[0].limit != ~`RESET_WORD
       && st.blk[0].prescale == ~`RESET_WORD && !req_i.wr)
      |=> st.blk[0].prescale == `RESET_WORD;
   endproperty
   a_wrap0: assert property (p_wrap0) else $error("block 0 prescale did not wrap"); // RL18

   property p_wrap1;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st.block_one_enable && !halted_a && st.blk[1].limit != ~`RESET_WORD
       && st.blk[1].prescale == ~`RESET_WORD && !req_i.wr)
      |=> st.blk[1].prescale == `RESET_WORD;
   endproperty
   a_wrap1: assert property (p_wrap1) else $error("block 1 prescale did not wrap"); // RL18

   // ----------------------------------------
   // Software presets and reads
   // ----------------------------------------
   property p_free_preset0;
      @(posedge clk_sys_i) disable iff (rst_i)
      (req_i.wr && req_i.addr == `OFS_FREE_RUNNING_0) |=> st.blk[0].free_run == $past(req_i.wdata);
   endproperty
   a_free_preset0: assert property (p_free_preset0) else $error("free running 0 not preset"); // RL1

   property p_free_preset1;
      @(posedge clk_sys_i) disable iff (rst_i)
      (req_i.wr && req_i.addr == `OFS_FREE_RUNNING_1) |=> st.blk[1].free_run == $past(req_i.wdata);
   endproperty
   a_free_preset1: assert property (p_free_preset1) else $error("free running 1 not preset"); // RL10

   property p_prescale_preset1;
      @(posedge clk_sys_i) disable iff (rst_i)
      (req_i.wr && req_i.addr == `OFS_PRESCALE_COUNT_1)
      |=> st.blk[1].prescale == $past(req_i.wdata) && st.blk[1].prescale_view == $past(req_i.wdata);
   endproperty
   a_prescale_preset1: assert property (p_prescale_preset1) else $error("prescale 1 not preset"); // RL13

   property p_limit_hold0;
      @(posedge clk_sys_i) disable iff (rst_i)
      !(req_i.wr && req_i.addr == `OFS_PRESCALE_COMPARE_0) |=> $stable(st.blk[0].limit);
   endproperty
   a_limit_hold0: assert property (p_limit_hold0) else $error("limit 0 changed unasked"); // RL3

   sequence s_free_read0;
      req_i.rd && req_i.addr == `OFS_FREE_RUNNING_0;
   endsequence

   sequence s_free_read1;
      req_i.rd && req_i.addr == `OFS_FREE_RUNNING_1;
   endsequence

   property p_read_free0;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_free_read0 |=> rdata_o == $past(st.blk[0].free_run);
   endproperty
   a_read_free0: assert property (p_read_free0) else $error("free running 0 read wrong"); // RL1

   property p_read_free1;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_free_read1 |=> rdata_o == $past(st.blk[1].free_run) && st.blk[1].prescale_view == $past(st.blk[1].prescale);
   endproperty
   a_read_free1: assert property (p_read_free1) else $error("free running 1 pair read wrong"); // RL12

   property p_view_steady0;
      @(posedge clk_sys_i) disable iff (rst_i)
      !((req_i.rd || req_i.wr) && (req_i.addr == `OFS_FREE_RUNNING_0 || req_i.addr == `OFS_PRESCALE_COUNT_0))
      |=> $stable(st.blk[0].prescale_view);
   endproperty
   a_view_steady0: assert property (p_view_steady0) else $error("prescale view 0 changed unasked"); // RL5

   // ----------------------------------------
   // Capture events and snapshot pairing
   // ----------------------------------------
   logic ev0_a;
   logic ev1_a;
   assign ev0_a = st.block_zero_capture_select ? (st.cap_src_sync[1] && !st.cap_src_prev[1])
                                               : (st.cap_src_sync[0] && !st.cap_src_prev[0]);
   assign ev1_a = st.block_one_capture_select ? (st.cap_src_sync[1] && !st.cap_src_prev[1])
                                              : (st.cap_src_sync[0] && !st.cap_src_prev[0]);

   property p_capture1;
      @(posedge clk_sys_i) disable iff (rst_i)
      ev1_a |=> st.blk[1].snap_free == $past(st.blk[1].free_run) && st.blk[1].snap_prescale == $past(st.blk[1].prescale);
   endproperty
   a_capture1: assert property (p_capture1) else $error("block 1 capture missed"); // RL14

   property p_snap_hold0;
      @(posedge clk_sys_i) disable iff (rst_i)
      !ev0_a |=> $stable(st.blk[0].snap_free) && $stable(st.blk[0].snap_prescale);
   endproperty
   a_snap_hold0: assert property (p_snap_hold0) else $error("block 0 snapshot moved without event"); // RL16

   property p_snap_hold1;
      @(posedge clk_sys_i) disable iff (rst_i)
      !ev1_a |=> $stable(st.blk[1].snap_free) && $stable(st.blk[1].snap_prescale);
   endproperty
   a_snap_hold1: assert property (p_snap_hold1) else $error("block 1 snapshot moved without event"); // RL16

   sequence s_snap_read0;
      req_i.rd && req_i.addr == `OFS_CAPT_FREE_0;
   endsequence

   property p_snap_pair0;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_snap_read0 |=> st.blk[0].snap_prescale_view == $past(st.blk[0].snap_prescale);
   endproperty
   a_snap_pair0: assert property (p_snap_pair0) else $error("block 0 snapshot pair broken"); // RL9

   property p_snap_read0;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_snap_read0 |=> rdata_o == $past(st.blk[0].snap_free);
   endproperty
   a_snap_read0: assert property (p_snap_read0) else $error("block 0 snapshot read wrong"); // RL7

endmodule // dual_prescaled_counter

// >>> hdl/prescaled_counter_params.svh
// Register offsets, field positions and reset values of the dual prescaled counter block
// Functional notes
// [RL1] Free-running counter 0 is readable anytime; a write presets it, counting continues.
// [RL2] Software disables a block before presetting either of its counters.
// [RL3] Prescale counter 0 equal to its limit clears it and increments free-running counter 0.
// [RL4] Free-running counter 0 advances at clock rate divided by limit plus one.
// [RL5] Readable prescale counter 0 is refreshed only by reading free-running counter 0; the code also loads it on a write to prescale counter 0.
// [RL6] Prescale counter 0 preset above limit matches only after wrapping through overflow.
// [RL7] Selected capture event copies free-running counter 0 into its snapshot register.
// [RL8] Same event copies prescale counter 0 into its snapshot register.
// [RL9] Prescale snapshot read after free-running snapshot read stays paired with it.
// [RL10] Free-running counter 1 updates continuously; a write presets it.
// [RL11] Prescale counter 1 equal to its limit clears it and increments free-running counter 1.
// [RL12] Readable prescale counter 1 is refreshed only by reading free-running counter 1; the code also loads it on a write to prescale counter 1.
// [RL13] Prescale counter 1 write presets it; above limit, match waits for overflow.
// [RL14] Block 1 capture latches both counters; snapshot read order keeps them paired.
// [RL15] Each block counts only while its enable bit is set.
// [RL16] Per block, one select bit picks capture source 0 or 1.
// [RL17] Debug suspend stops all counters unless continue-on-suspend is set.
// [RL18] Every 32-bit counter wraps from all ones to zero.
`ifndef PRESCALED_COUNTER_PARAMS_SVH
`define PRESCALED_COUNTER_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_GLOBAL_CONTROL     8'h00
`define OFS_CAPTURE_SOURCE     8'h08
`define OFS_FREE_RUNNING_0     8'h10
`define OFS_PRESCALE_COUNT_0   8'h14
`define OFS_PRESCALE_COMPARE_0 8'h18
`define OFS_CAPT_FREE_0        8'h20
`define OFS_CAPT_PRESCALE_0    8'h24
`define OFS_FREE_RUNNING_1     8'h30
`define OFS_PRESCALE_COUNT_1   8'h34
`define OFS_PRESCALE_COMPARE_1 8'h38
`define OFS_CAPT_FREE_1        8'h40
`define OFS_CAPT_PRESCALE_1    8'h44

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BIT_BLOCK_ZERO_ENABLE  0
`define BIT_BLOCK_ONE_ENABLE   1
`define BIT_CONTINUE_SUSPEND   15
`define BIT_BLOCK_ZERO_CAPSEL  0
`define BIT_BLOCK_ONE_CAPSEL   1
`define RESET_WORD             32'h0000_0000
`define UNMAPPED_READ          32'h0000_0000
`define COUNT_STEP             32'h0000_0001

`endif

// >>> hdl/prescaled_counter_pkg.sv
// Types shared by the dual prescaled counter block
package prescaled_counter_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic [31:0] free_run;
      logic [31:0] prescale;
      logic [31:0] limit;
      logic [31:0] prescale_view;
      logic [31:0] snap_free;
      logic [31:0] snap_prescale;
      logic [31:0] snap_prescale_view;
   } counter_block_t;

   typedef struct packed {
      counter_block_t [1:0] blk;
      logic                 block_zero_enable;
      logic                 block_one_enable;
      logic                 continue_on_suspend;
      logic                 block_zero_capture_select;
      logic                 block_one_capture_select;
      logic [31:0]          rdata;
      logic [1:0]           cap_src_meta;
      logic [1:0]           cap_src_sync;
      logic [1:0]           cap_src_prev;
      logic                 suspend_meta;
      logic                 suspend_sync;
   } counter_state_t;

endpackage

// >>> sim/dual_prescaled_counter_test.sv
// Self-checking bench of the dual prescaled counter block
`timescale 1ns/1ps
`include "prescaled_counter_params.svh"

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module dual_prescaled_counter_test;
   import prescaled_counter_pkg::*;

   logic        clk_sys_i        = 1'b0;
   logic        rst_i            = 1'b1;
   reg_req_t    req              = '0;
   logic [31:0] rdata_o;
   logic [1:0]  capture_source_i = 2'h0;
   logic        suspend_i        = 1'b0;
   int          n_fail           = 0;
   int          checks           = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   dual_prescaled_counter dut
   (
      .clk_sys_i        (clk_sys_i),
      .rst_i            (rst_i),
      .req_i            (req),
      .rdata_o          (rdata_o),
      .capture_source_i (capture_source_i),
      .suspend_i        (suspend_i)
   );

   // ----------------------------------------
   // Register port and event helpers
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      req.wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      req.rd <= 1'b0;
      #1;
      `CHK(nm, e, rdata_o)
   endtask

   // Held two cycles so the synchroniser cannot miss it
   task automatic pulse(input int i);
      @(posedge clk_sys_i);
      capture_source_i[i] <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      capture_source_i[i] <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
   endtask

   task give_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic regs_reset;
      logic [7:0] map [13];
      map = '{`OFS_GLOBAL_CONTROL, `OFS_CAPTURE_SOURCE, `OFS_FREE_RUNNING_0, `OFS_PRESCALE_COUNT_0,
              `OFS_PRESCALE_COMPARE_0, `OFS_CAPT_FREE_0, `OFS_CAPT_PRESCALE_0, `OFS_FREE_RUNNING_1,
              `OFS_PRESCALE_COUNT_1, `OFS_PRESCALE_COMPARE_1, `OFS_CAPT_FREE_1, `OFS_CAPT_PRESCALE_1, 8'h4c};
      foreach (map[i])
         rd_chk(map[i], 32'h0, "reset value");
      wr(`OFS_CAPT_FREE_0, 32'hffff_ffff);
      rd_chk(`OFS_CAPT_FREE_0, 32'h0, "read-only snapshot");
      wr(`OFS_CAPT_PRESCALE_1, 32'hffff_ffff);
      rd_chk(`OFS_CAPT_PRESCALE_1, 32'h0, "read-only snapshot");
      wr(`OFS_CAPTURE_SOURCE, 32'hffff_ffff);
      rd_chk(`OFS_CAPTURE_SOURCE, 32'h0000_0003, "capture select");
      // Enable bits kept clear so nothing starts counting here
      wr(`OFS_GLOBAL_CONTROL, 32'hffff_fffc);
      rd_chk(`OFS_GLOBAL_CONTROL, 32'h0000_8000, "global control");
      wr(`OFS_GLOBAL_CONTROL, 32'h0);
   endtask

   // Counters stay disabled, so every captured value is known
   task automatic cap(input int b, input logic sel);
      logic [7:0] base;
      base = (b != 0) ? 8'h30 : 8'h10;
      wr(`OFS_CAPTURE_SOURCE, {31'h0, sel} << b);
      wr(base, 32'h0000_0100 + b);
      wr(base + 8'h04, 32'h0000_0007);
      pulse(int'(!sel));
      rd_chk(base + 8'h10, 32'h0, "snapshot after unselected source");
      rd_chk(base + 8'h14, 32'h0, "snapshot after unselected source");
      pulse(int'(sel));
      rd_chk(base + 8'h10, 32'h0000_0100 + b, "free running snapshot");
      wr(base, 32'h0000_0200);
      wr(base + 8'h04, 32'h0000_0009);
      pulse(int'(sel));
      rd_chk(base + 8'h14, 32'h0000_0007, "paired prescale snapshot");
      rd_chk(base + 8'h10, 32'h0000_0200, "free running snapshot");
      rd_chk(base + 8'h14, 32'h0000_0009, "prescale snapshot");
   endtask

   // Counts for exactly t clocks between the enabling and disabling writes
   task automatic run(input int b, input logic [31:0] ctl, lim, pre, fr, input int t,
                      input logic [31:0] efr, epr);
      logic [7:0] base;
      base = (b != 0) ? 8'h30 : 8'h10;
      wr(`OFS_GLOBAL_CONTROL, 32'h0);
      wr(base + 8'h08, lim);
      wr(base + 8'h04, pre);
      wr(base, fr);
      wr(`OFS_GLOBAL_CONTROL, ctl);
      repeat (t - 2) @(posedge clk_sys_i);
      wr(`OFS_GLOBAL_CONTROL, 32'h0);
      rd_chk(base + 8'h04, pre, "prescale view before pair read");
      rd_chk(base, efr, "free running count");
      rd_chk(base + 8'h04, epr, "prescale count");
      rd_chk(base + 8'h08, lim, "prescale limit");
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      regs_reset();
      cap(0, 1'b1);
      cap(1, 1'b0);
      run(0, 32'h0000_0001, 32'h3, 32'h0, 32'h0, 11, 32'h2, 32'h3);
      run(1, 32'h0000_0002, 32'h3, 32'hffff_fffe, 32'h5, 4, 32'h5, 32'h2);
      run(0, 32'h0000_0001, 32'h1, 32'hffff_fffd, 32'hffff_ffff, 6, 32'h0, 32'h1);
      suspend_i <= 1'b1;
      run(0, 32'h0000_0001, 32'h0, 32'h0, 32'h7, 8, 32'h7, 32'h0);
      run(0, 32'h0000_8001, 32'h0, 32'h0, 32'h7, 8, 32'hf, 32'h0);
      give_verdict();
   end

   // Whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk_sys_i);
      n_fail++;
      give_verdict();
   end

endmodule // dual_prescaled_counter_test
